// >>> core/rsm_ref_select.sv
// Reference switchover, power and monitor pin control with AXI4-Lite access.
`timescale 1ns/1ns

// Overview of operation
// - Code 10111 drives inverted first reference valid, low meaning good.
// - Code 11000 drives inverted second reference valid.
// - Code 11001 drives first valid AND second valid.
// - Code 11010 drives lock AND selected valid AND oscillator valid.
// - Code 11011 drives inverted oscillator valid.
// - Code 11100 drives low for second reference, high for first.
// - Code 11101 drives inverted lock; 11110 drives inverted holdover flag.
// - Manual register selection uses second reference when bit 6 set.
// - Bit 5 chooses register bit (clear) or select pin (set).
// - Bit 4 enables automatic switchover, powering both references.
// - Automatic mode returns to first reference; with bit 3 set, only once second fails.
// - Bits 2 and 1 power second and first; ignored in automatic.
// - Bit 0 selects single-ended (clear) or differential reference mode.
// - Top-bit-zero codes give the same functions with active-high sense.
module rsm_ref_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rsm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rsm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rsm_pkg::rsm_status_t status_in,
  output rsm_pkg::rsm_pll_ctrl_t pll_ctrl,
  output logic monitor_pin,
  output logic irq
);

  // ==========================================================
  // Input synchronisers
  rsm_pkg::rsm_status_t status_meta;
  rsm_pkg::rsm_status_t status_sync;
  rsm_pkg::rsm_status_t status_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_meta <= '0;
      status_sync <= '0;
      status_prev <= '0;
    end else begin
      status_meta <= status_in;
      status_sync <= status_meta;
      status_prev <= status_sync;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] ref_ctrl;
  logic [4:0] mon_sel;
  logic [rsm_pkg::IRQ_W-1:0] irq_status;
  logic [rsm_pkg::IRQ_W-1:0] irq_mask;

  // ==========================================================
  // AXI4-Lite write channel
  logic aw_full;
  logic w_full;
  logic [rsm_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_full && w_full && !s_axi_bvalid;
  wire wr_low = wr_fire && w_strb[0];
  wire wr_ctrl = aw_addr == rsm_pkg::ADDR_REF_CTRL;
  wire wr_mon = aw_addr == rsm_pkg::ADDR_MON_SEL;
  wire wr_istat = aw_addr == rsm_pkg::ADDR_IRQ_STATUS;
  wire wr_imask = aw_addr == rsm_pkg::ADDR_IRQ_MASK;
  wire wr_state = aw_addr == rsm_pkg::ADDR_STATE;
  wire wr_mapped = wr_ctrl || wr_mon || wr_istat || wr_imask || wr_state;
  wire next_aw_full = wr_fire ? 1'b0 : (aw_full || aw_take);
  wire next_w_full = wr_fire ? 1'b0 : (w_full || w_take);
  wire [rsm_pkg::IRQ_W-1:0] irq_clear =
    (wr_low && wr_istat) ? w_data[rsm_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rsm_pkg::RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= !next_aw_full;
      s_axi_wready <= !next_w_full;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? rsm_pkg::RESP_OKAY : rsm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_ctrl <= rsm_pkg::REF_CTRL_RESET;
      mon_sel <= rsm_pkg::MON_SEL_RESET;
      irq_mask <= rsm_pkg::IRQ_RESET;
    end else if (wr_low) begin
      if (wr_ctrl) begin
        ref_ctrl <= w_data[7:0];
      end
      if (wr_mon) begin
        mon_sel <= w_data[4:0];
      end
      if (wr_imask) begin
        irq_mask <= w_data[rsm_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // Reference selection
  rsm_pkg::rsm_ref_state_t auto_state;
  rsm_pkg::rsm_ref_state_t next_auto_state;
  rsm_pkg::rsm_ref_state_t target;
  logic [rsm_pkg::DEGLITCH_W-1:0] settle_cnt;

  wire first_ok = status_sync.first_reference_valid;
  wire second_ok = status_sync.second_reference_valid;
  wire auto_mode = ref_ctrl[rsm_pkg::CTL_AUTO];
  wire diff_mode = ref_ctrl[rsm_pkg::CTL_DIFF];
  wire bypass = ref_ctrl[rsm_pkg::CTL_DEGLITCH_OFF];
  wire manual_second = ref_ctrl[rsm_pkg::CTL_USE_PIN] ?
    status_sync.ref_sel_pin : ref_ctrl[rsm_pkg::CTL_SEL_SECOND];
  wire using_second = pll_ctrl.use_second_reference;
  wire settled = settle_cnt >= rsm_pkg::DEGLITCH_CYCLES;
  wire pending = target != rsm_pkg::rsm_ref_state_t'(using_second);
  wire do_switch = pending && (bypass || settled);
  wire first_power_next = auto_mode || ref_ctrl[rsm_pkg::CTL_PWR_FIRST];
  wire second_power_next = auto_mode || ref_ctrl[rsm_pkg::CTL_PWR_SECOND];

  // A lost reference moves the loop only when the other one is good, so a
  // double failure leaves the choice alone and holdover can take over.
  always_comb begin
    next_auto_state = auto_state;
    if (!auto_mode) begin
      next_auto_state = rsm_pkg::rsm_ref_state_t'(manual_second);
    end else begin
      unique case (auto_state)
        rsm_pkg::RSM_ON_FIRST: begin
          if (!first_ok && second_ok) begin
            next_auto_state = rsm_pkg::RSM_ON_SECOND;
          end
        end
        rsm_pkg::RSM_ON_SECOND: begin
          if (first_ok && !ref_ctrl[rsm_pkg::CTL_STAY_SECOND]) begin
            next_auto_state = rsm_pkg::RSM_ON_FIRST;
          end else if (first_ok && !second_ok) begin
            next_auto_state = rsm_pkg::RSM_ON_FIRST;
          end
        end
      endcase
    end
  end

  // Differential mode has only the one reference input to offer.
  always_comb begin
    if (diff_mode) begin
      target = rsm_pkg::RSM_ON_FIRST;
    end else if (auto_mode) begin
      target = auto_state;
    end else begin
      target = rsm_pkg::rsm_ref_state_t'(manual_second);
    end
  end

  // The deglitcher waits for the request to stay put before moving the
  // multiplexer, which trades a short delay for a runt-free PLL input.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_state <= rsm_pkg::RSM_ON_FIRST;
      settle_cnt <= '0;
      pll_ctrl <= '0;
    end else begin
      auto_state <= next_auto_state;
      if (!pending || do_switch) begin
        settle_cnt <= '0;
      end else if (!settled) begin
        settle_cnt <= settle_cnt + 1'b1;
      end
      if (do_switch) begin
        pll_ctrl.use_second_reference <= target == rsm_pkg::RSM_ON_SECOND;
      end
      pll_ctrl.first_reference_power <= first_power_next;
      pll_ctrl.second_reference_power <= second_power_next;
      pll_ctrl.diff_mode <= diff_mode;
      pll_ctrl.deglitch_bypass <= bypass;
    end
  end

  // ==========================================================
  // Monitor pin
  wire sel_ok = using_second ? second_ok : first_ok;
  wire unsel_ok = using_second ? first_ok : second_ok;
  wire [3:0] mon_fn = mon_sel[3:0];
  wire mon_upper = mon_sel[4];
  logic mon_base;

  always_comb begin
    unique case (mon_fn)
      rsm_pkg::MON_SEL_STATUS: mon_base = sel_ok;
      rsm_pkg::MON_UNSEL_STATUS: mon_base = unsel_ok;
      rsm_pkg::MON_FIRST_STATUS: mon_base = first_ok;
      rsm_pkg::MON_SECOND_STATUS: mon_base = second_ok;
      rsm_pkg::MON_BOTH_VALID: mon_base = first_ok && second_ok;
      rsm_pkg::MON_ALL_GOOD: mon_base = status_sync.digital_lock_flag &&
        sel_ok && status_sync.osc_valid;
      rsm_pkg::MON_OSC_STATUS: mon_base = status_sync.osc_valid;
      rsm_pkg::MON_IN_USE: mon_base = using_second;
      rsm_pkg::MON_LOCK: mon_base = status_sync.digital_lock_flag;
      rsm_pkg::MON_HOLDOVER: mon_base = status_sync.holdover;
      default: mon_base = 1'b0;
    endcase
  end

  // Toggling clock codes cannot be routed here and read as ground. The
  // upper ground code stands for the supply and reads high.
  wire mon_invert = mon_upper && (mon_fn != rsm_pkg::MON_BOTH_VALID) &&
    (mon_fn != rsm_pkg::MON_ALL_GOOD) && (mon_fn != rsm_pkg::MON_RESERVED) &&
    ((mon_fn == rsm_pkg::MON_GROUND) || (mon_fn >= rsm_pkg::MON_SEL_STATUS));
  wire next_monitor = mon_base ^ mon_invert;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_pin <= 1'b0;
    end else begin
      monitor_pin <= next_monitor;
    end
  end

  // ==========================================================
  // Interrupts
  logic [rsm_pkg::IRQ_W-1:0] irq_event;

  always_comb begin
    irq_event = '0;
    irq_event[rsm_pkg::IRQ_SWITCH] = do_switch;
    irq_event[rsm_pkg::IRQ_FIRST_LOST] =
      status_prev.first_reference_valid && !first_ok;
    irq_event[rsm_pkg::IRQ_SECOND_LOST] =
      status_prev.second_reference_valid && !second_ok;
    irq_event[rsm_pkg::IRQ_LOCK_LOST] =
      status_prev.digital_lock_flag && !status_sync.digital_lock_flag;
  end

  // A new event wins over a clear written in the same cycle.
  wire [rsm_pkg::IRQ_W-1:0] next_irq_status =
    (irq_status & ~irq_clear) | irq_event;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= rsm_pkg::IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [31:0] state_word = {24'h000000, 1'b0, monitor_pin,
    status_sync.holdover, status_sync.digital_lock_flag,
    status_sync.osc_valid, second_ok, first_ok, using_second};
  wire rd_ctrl = s_axi_araddr == rsm_pkg::ADDR_REF_CTRL;
  wire rd_mon = s_axi_araddr == rsm_pkg::ADDR_MON_SEL;
  wire rd_istat = s_axi_araddr == rsm_pkg::ADDR_IRQ_STATUS;
  wire rd_imask = s_axi_araddr == rsm_pkg::ADDR_IRQ_MASK;
  wire rd_state = s_axi_araddr == rsm_pkg::ADDR_STATE;
  wire rd_mapped = rd_ctrl || rd_mon || rd_istat || rd_imask || rd_state;
  wire [31:0] rd_word =
    rd_ctrl ? {24'h000000, ref_ctrl} :
    rd_mon ? {27'h0000000, mon_sel} :
    rd_istat ? {28'h0000000, irq_status} :
    rd_imask ? {28'h0000000, irq_mask} :
    rd_state ? state_word : 32'h00000000;
  wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= rsm_pkg::RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= !next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? rsm_pkg::RESP_OKAY : rsm_pkg::RESP_SLVERR;
      end
    end
  end

endmodule

// >>> shared/rsm_pkg.sv
// Constants, field layouts and carrier types of the reference selector.
package rsm_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned DEGLITCH_NS = 200;
  localparam int unsigned DEGLITCH_CYCLES_INT =
    (DEGLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DEGLITCH_W = 3;
  localparam logic [DEGLITCH_W-1:0] DEGLITCH_CYCLES =
    DEGLITCH_W'(DEGLITCH_CYCLES_INT);

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_REF_CTRL = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_MON_SEL = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h2C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Reference control fields
  localparam int unsigned CTL_DEGLITCH_OFF = 7;
  localparam int unsigned CTL_SEL_SECOND = 6;
  localparam int unsigned CTL_USE_PIN = 5;
  localparam int unsigned CTL_AUTO = 4;
  localparam int unsigned CTL_STAY_SECOND = 3;
  localparam int unsigned CTL_PWR_SECOND = 2;
  localparam int unsigned CTL_PWR_FIRST = 1;
  localparam int unsigned CTL_DIFF = 0;
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  localparam logic [4:0] MON_SEL_RESET = 5'h00;

  // ==========================================================
  // Monitor selector codes with shared meaning in both halves
  localparam logic [3:0] MON_GROUND = 4'h0;
  localparam logic [3:0] MON_SEL_STATUS = 4'h5;
  localparam logic [3:0] MON_UNSEL_STATUS = 4'h6;
  localparam logic [3:0] MON_FIRST_STATUS = 4'h7;
  localparam logic [3:0] MON_SECOND_STATUS = 4'h8;
  localparam logic [3:0] MON_BOTH_VALID = 4'h9;
  localparam logic [3:0] MON_ALL_GOOD = 4'hA;
  localparam logic [3:0] MON_OSC_STATUS = 4'hB;
  localparam logic [3:0] MON_IN_USE = 4'hC;
  localparam logic [3:0] MON_LOCK = 4'hD;
  localparam logic [3:0] MON_HOLDOVER = 4'hE;
  localparam logic [3:0] MON_RESERVED = 4'hF;

  // ==========================================================
  // Interrupt status bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_SWITCH = 0;
  localparam int unsigned IRQ_FIRST_LOST = 1;
  localparam int unsigned IRQ_SECOND_LOST = 2;
  localparam int unsigned IRQ_LOCK_LOST = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic ref_sel_pin;
    logic holdover;
    logic digital_lock_flag;
    logic osc_valid;
    logic second_reference_valid;
    logic first_reference_valid;
  } rsm_status_t;

  typedef struct packed {
    logic deglitch_bypass;
    logic diff_mode;
    logic second_reference_power;
    logic first_reference_power;
    logic use_second_reference;
  } rsm_pll_ctrl_t;

  typedef enum logic {
    RSM_ON_FIRST = 1'b0,
    RSM_ON_SECOND = 1'b1
  } rsm_ref_state_t;

endpackage

// >>> verification/rsm_ref_src.sv
// Behavioural reference sources and select pin feeding the status inputs.
`timescale 1ns/1ns
module rsm_ref_src (
  input wire logic aclk,
  input wire logic [5:0] want,
  output rsm_pkg::rsm_status_t status
);
  // Levels only move after an edge, like a real frequency monitor.
  initial status = '0;
  always @(posedge aclk) begin
    status <= rsm_pkg::rsm_status_t'(want);
  end
endmodule

// >>> verification/rsm_ref_select_sva.sv
// Checker of reference selection, power and monitor pin behaviour.
`timescale 1ns/1ns
module rsm_ref_select_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rsm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire rsm_pkg::rsm_status_t status_in,
  input wire rsm_pkg::rsm_pll_ctrl_t pll_ctrl,
  input wire logic monitor_pin
);
  logic [7:0] ctl, wd, wa;
  logic [4:0] msel;
  logic [3:0] quiet, sq;
  logic [1:0] pwr, mb;
  logic ws, bv_q, fire, calm, settled, manual;
  logic f1, f2, ok, lk, ho, u2, sel;
  rsm_pkg::rsm_status_t st;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  assign fire = s_axi_bvalid && !bv_q && ws &&
    s_axi_bresp == rsm_pkg::RESP_OKAY;
  assign f1 = st.first_reference_valid;
  assign f2 = st.second_reference_valid;
  assign ok = st.osc_valid;
  assign lk = st.digital_lock_flag;
  assign ho = st.holdover;
  assign u2 = pll_ctrl.use_second_reference;
  assign sel = u2 ? f2 : f1;
  assign pwr = {pll_ctrl.second_reference_power,
    pll_ctrl.first_reference_power};
  assign mb = {pll_ctrl.deglitch_bypass, pll_ctrl.diff_mode};
  assign calm = quiet >= 4'h2 && !fire;
  assign settled = quiet >= 4'hC && sq >= 4'hC && !fire;
  assign manual = ctl[5:4] == 2'h0 && !ctl[0];
  // ==========================================================
  // Write shadow
  // It lags the slave by one cycle, so checks wait for quiet time.
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
    bv_q <= aresetn && s_axi_bvalid;
    st <= status_in;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ctl <= 8'h00;
    else if (fire && wa == rsm_pkg::ADDR_REF_CTRL) ctl <= wd;
    if (!aresetn) msel <= 5'h00;
    else if (fire && wa == rsm_pkg::ADDR_MON_SEL) msel <= wd[4:0];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || fire) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    if (!aresetn || st != status_in) sq <= 4'h0;
    else if (sq != 4'hF) sq <= sq + 4'h1;
  end
  // ==========================================================
  // Properties
  property p_mon(logic [4:0] c, logic v);
    settled && msel == c |-> monitor_pin == v;
  endproperty
  // Taken in the cycle the write lands, so an instant switch is still seen.
  sequence s_pend;
    fire && wa == rsm_pkg::ADDR_REF_CTRL && quiet >= 4'h5 && !wd[7] &&
      wd[5:4] == 2'h0 && !wd[0] && u2 != wd[6];
  endsequence
  sequence s_bypass;
    quiet == 4'h0 && ctl[7] && manual;
  endsequence
  chk_mon_first: assert property (p_mon(5'h17, !f1))
    else $error("monitor code 17 wrong");
  chk_mon_second: assert property (p_mon(5'h18, !f2))
    else $error("monitor code 18 wrong");
  chk_mon_both: assert property (p_mon(5'h19, f1 && f2))
    else $error("monitor code 19 wrong");
  chk_mon_all: assert property (p_mon(5'h1A, lk && sel && ok))
    else $error("monitor code 1A wrong");
  chk_mon_osc: assert property (p_mon(5'h1B, !ok))
    else $error("monitor code 1B wrong");
  chk_mon_in_use: assert property (p_mon(5'h1C, !u2))
    else $error("monitor code 1C wrong");
  chk_mon_lock: assert property (p_mon(5'h1D, !lk))
    else $error("monitor code 1D wrong");
  chk_mon_hold: assert property (p_mon(5'h1E, !ho))
    else $error("monitor code 1E wrong");
  chk_mon_reserved: assert property (p_mon(5'h1F, 1'b0))
    else $error("monitor code 1F not low");
  chk_power_on: assert property (calm |->
    pwr == ({2{ctl[4]}} | ctl[2:1]))
    else $error("reference power wrong");
  chk_mode_bits: assert property (calm |-> mb == {ctl[7], ctl[0]})
    else $error("mode bits wrong");
  chk_manual_sel: assert property (settled && manual |-> u2 == ctl[6])
    else $error("manual selection wrong");
  chk_pin_sel: assert property (settled && ctl[5:4] == 2'h2 &&
    !ctl[0] |-> u2 == st.ref_sel_pin)
    else $error("pin selection wrong");
  chk_auto_back: assert property (settled && ctl[4] && !ctl[3] &&
    !ctl[0] && f1 |-> !u2)
    else $error("no return to first reference");
  chk_no_glitch: assert property (s_pend |=> $stable(u2) [*3])
    else $error("switch without deglitch delay");
  chk_fast_switch: assert property (s_bypass |-> u2 == ctl[6])
    else $error("bypassed switch late");
endmodule
bind rsm_ref_select rsm_ref_select_sva rsm_ref_select_sva_i (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .status_in, .pll_ctrl, .monitor_pin);

// >>> verification/tb_rsm_ref_select.sv
// Self-checking bench of the reference selector.
`timescale 1ns/1ns
module tb_rsm_ref_select;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, monitor_pin, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] want = 6'h00;
  rsm_pkg::rsm_status_t status_in;
  rsm_pkg::rsm_pll_ctrl_t pll_ctrl;
  int n_mismatch = 0;
  int checked = 0;
  always #25 aclk = ~aclk;
  rsm_ref_src rsm_ref_src_i (.aclk, .want, .status(status_in));
  rsm_ref_select rsm_ref_select_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .status_in, .pll_ctrl, .monitor_pin, .irq);
  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = rsm_pkg::RESP_OKAY);
    int n;
    n = 0;
    // One edge between calls keeps bready from being driven twice at once.
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) begin
      n_mismatch++;
      report_and_stop();
    end
    check(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er = rsm_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) begin
      n_mismatch++;
      report_and_stop();
    end
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
  endtask
  task automatic ctl(input logic [31:0] d, input int n);
    wr(rsm_pkg::ADDR_REF_CTRL, d);
    tick(n);
  endtask
  task automatic src(input logic [5:0] s, input int n);
    want <= s;
    tick(n);
  endtask
  // The first reference stays selected while the monitor is swept.
  function automatic logic mon_exp(input logic [4:0] c, input logic [5:0] s);
    logic v;
    case (c[3:0])
      4'h7: v = s[0];
      4'h8: v = s[1];
      4'h9: v = s[0] & s[1];
      4'hA: v = s[3] & s[0] & s[2];
      4'hB: v = s[2];
      4'hD: v = s[3];
      4'hE: v = s[4];
      default: v = 1'b0;
    endcase
    if (c[4] && c[3:0] != 4'h9 && c[3:0] != 4'hA && c[3:0] != 4'hF) v = !v;
    return v;
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    check(pll_ctrl, 5'h00);
    rd(rsm_pkg::ADDR_REF_CTRL, 32'h0);
    rd(8'h40, 32'h0, rsm_pkg::RESP_SLVERR);
    wr(8'h40, 32'hFF, rsm_pkg::RESP_SLVERR);
    wr(rsm_pkg::ADDR_REF_CTRL, 32'hFFFF_FFA5);
    rd(rsm_pkg::ADDR_REF_CTRL, 32'hA5);
  endtask
  task automatic t_manual();
    src(6'h03, 4);
    ctl(32'h46, 1);
    check(pll_ctrl.use_second_reference, 1'b0);
    tick(10);
    check(pll_ctrl, 5'h07);
    ctl(32'h80, 1);
    check(pll_ctrl, 5'h10);
    ctl(32'h04, 10);
    check(pll_ctrl, 5'h04);
    ctl(32'h01, 10);
    check(pll_ctrl, 5'h08);
  endtask
  task automatic t_pin();
    ctl(32'h60, 12);
    check(pll_ctrl, 5'h00);
    src(6'h23, 14);
    check(pll_ctrl.use_second_reference, 1'b1);
    src(6'h03, 14);
    check(pll_ctrl.use_second_reference, 1'b0);
  endtask
  task automatic t_auto();
    ctl(32'h10, 10);
    check(pll_ctrl, 5'h06);
    src(6'h02, 14);
    check(pll_ctrl, 5'h07);
    src(6'h03, 14);
    check(pll_ctrl, 5'h06);
    ctl(32'h18, 4);
    src(6'h02, 14);
    src(6'h03, 14);
    check(pll_ctrl, 5'h07);
  endtask
  task automatic t_mon();
    logic e;
    ctl(32'h00, 14);
    for (int p = 0; p < 2; p++) begin
      src(p ? 6'h30 : 6'h0F, 12);
      for (int i = 7; i < 32; i++) begin
        if ((i % 16) >= 7) begin
          wr(rsm_pkg::ADDR_MON_SEL, 32'(i));
          tick(14);
          e = mon_exp(5'(i), want);
          check(monitor_pin, e);
        end
      end
    end
  endtask
  task automatic t_irq();
    src(6'h0F, 8);
    wr(rsm_pkg::ADDR_IRQ_STATUS, 32'hF);
    wr(rsm_pkg::ADDR_IRQ_MASK, 32'h2);
    src(6'h0E, 8);
    check(irq, 1'b1);
    rd(rsm_pkg::ADDR_IRQ_STATUS, 32'h2);
    wr(rsm_pkg::ADDR_IRQ_MASK, 32'h0);
    tick(2);
    check(irq, 1'b0);
    wr(rsm_pkg::ADDR_IRQ_MASK, 32'h2);
    wr(rsm_pkg::ADDR_IRQ_STATUS, 32'h2);
    tick(2);
    check(irq, 1'b0);
    rd(rsm_pkg::ADDR_IRQ_STATUS, 32'h0);
  endtask
  initial begin
    tick(12);
    aresetn <= 1'b1;
    tick(1);
    t_regs();
    t_manual();
    t_pin();
    t_auto();
    t_mon();
    t_irq();
    report_and_stop();
  end
endmodule
